// ==== logic/rlds_bank.sv ====
// Lane debug status bank with read-only status words and maskable event interrupts
//
// What this block does
// - Two-bit frame alignment state per lane at 0xF4
// - Bit 16+n at 0xF8 while lane buffer empty
// - Bit n at 0xF8 while sync buffer full
// - Bit 16+n at 0xFC once config data starts
// - Bit n at 0xFC once user phase entered
`timescale 1ns/1ps
module rlds_bank (
	input  wire logic                 clk_sys_in,
	input  wire logic                 rst_n_in,
	input  wire logic [7:0]           reg_addr_in,
	input  wire logic [31:0]          reg_wdata_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	input  wire rlds_pkg::rlds_lane_t lane_in,
	output logic      [31:0]          reg_rdata_out,
	output logic                      irq_out
);
	rlds_pkg::rlds_req_t req;
	rlds_pkg::rlds_lane_t lane_s;

	logic [31:0] frame_align_word;
	logic [31:0] buf_level_word;
	logic [31:0] phase_word;
	logic [15:0] irq_status;
	logic [15:0] irq_mask;
	logic [7:0]  cfg_prev;
	logic [7:0]  user_prev;

	wire  [15:0] phase_events;
	wire  [15:0] next_irq_status;
	wire  [15:0] next_irq_mask;
	wire         next_irq;
	wire  [31:0] next_rdata;
	wire  [31:0] next_frame_align;
	wire  [31:0] next_buf_level;
	wire  [31:0] next_phase;
	wire         sel_status_wr;
	wire         sel_mask_wr;

	assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

	// Lane flags come from the link-layer clock domain
	rlds_sync #(
		.WIDTH ($bits(rlds_pkg::rlds_lane_t))
	) u_sync (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.async_in   (lane_in),
		.sync_out   (lane_s)
	);

	// Packs an 8-bit high and low flag group with reserved zero bytes
	function automatic logic [31:0] pack_flags(input logic [7:0] hi, input logic [7:0] lo);
		logic [31:0] w;
		w = rlds_pkg::STATUS_RESET;
		w[rlds_pkg::HI_FLAG_POS +: rlds_pkg::LANES] = hi;
		w[rlds_pkg::LO_FLAG_POS +: rlds_pkg::LANES] = lo;
		return w;
	endfunction

	assign next_frame_align = {16'h0000, lane_s.frame_align_state};
	assign next_buf_level   = pack_flags(lane_s.rx_buffer_empty,
		lane_s.sync_buffer_full);
	assign next_phase       = pack_flags(lane_s.align_config_started,
		lane_s.user_payload_phase);

	// Rising edges of the phase flags raise events
	assign phase_events = {lane_s.user_payload_phase & ~user_prev,
		lane_s.align_config_started & ~cfg_prev};

	assign sel_status_wr = req.wr && (req.addr == rlds_pkg::IRQ_STATUS_OFF);
	assign sel_mask_wr   = req.wr && (req.addr == rlds_pkg::IRQ_MASK_OFF);

	// Set wins over write-one-to-clear
	assign next_irq_status = phase_events |
		(irq_status & ~(sel_status_wr ? req.wdata[15:0] : 16'h0000));
	assign next_irq_mask   = sel_mask_wr ? req.wdata[15:0] : irq_mask;
	assign next_irq        = |(next_irq_status & next_irq_mask);

	// Status words have no write path; unmapped reads return zero
	assign next_rdata =
		!req.rd                                   ? rlds_pkg::UNMAPPED_DATA :
		(req.addr == rlds_pkg::FRAME_ALIGN_OFF)   ? frame_align_word :
		(req.addr == rlds_pkg::BUF_LEVEL_OFF)     ? buf_level_word :
		(req.addr == rlds_pkg::PHASE_OFF)         ? phase_word :
		(req.addr == rlds_pkg::IRQ_STATUS_OFF)    ? {16'h0000, irq_status} :
		(req.addr == rlds_pkg::IRQ_MASK_OFF)      ? {16'h0000, irq_mask} :
		                                            rlds_pkg::UNMAPPED_DATA;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_align_word <= rlds_pkg::STATUS_RESET;
			buf_level_word   <= rlds_pkg::STATUS_RESET;
			phase_word       <= rlds_pkg::STATUS_RESET;
			irq_status       <= rlds_pkg::IRQ_RESET;
			irq_mask         <= rlds_pkg::IRQ_RESET;
			cfg_prev         <= '0;
			user_prev        <= '0;
			reg_rdata_out    <= rlds_pkg::UNMAPPED_DATA;
			irq_out          <= 1'b0;
		end else begin
			frame_align_word <= next_frame_align;
			buf_level_word   <= next_buf_level;
			phase_word       <= next_phase;
			irq_status       <= next_irq_status;
			irq_mask         <= next_irq_mask;
			cfg_prev         <= lane_s.align_config_started;
			user_prev        <= lane_s.user_payload_phase;
			reg_rdata_out    <= next_rdata;
			irq_out          <= next_irq;
		end
	end
endmodule

// ==== logic/rlds_pkg.sv ====
// Package of offsets, field layouts and types for the lane debug status bank
package rlds_pkg;
	localparam int          LANES          = 8;
	localparam int          ADDR_W         = 8;
	localparam logic [7:0]  FRAME_ALIGN_OFF = 8'hf4;
	localparam logic [7:0]  BUF_LEVEL_OFF   = 8'hf8;
	localparam logic [7:0]  PHASE_OFF       = 8'hfc;
	localparam logic [7:0]  IRQ_STATUS_OFF  = 8'he0;
	localparam logic [7:0]  IRQ_MASK_OFF    = 8'he4;
	localparam int          HI_FLAG_POS     = 16;
	localparam int          LO_FLAG_POS     = 0;
	localparam int          IRQ_CFG_POS     = 0;
	localparam int          IRQ_USER_POS    = 8;
	localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
	localparam logic [15:0] IRQ_RESET       = 16'h0000;
	localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

	// Per-lane inputs from the link layer
	typedef struct packed {
		logic [15:0] frame_align_state;
		logic [7:0]  rx_buffer_empty;
		logic [7:0]  sync_buffer_full;
		logic [7:0]  align_config_started;
		logic [7:0]  user_payload_phase;
	} rlds_lane_t;

	// Register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} rlds_req_t;
endpackage

// ==== logic/rlds_sync.sv ====
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module rlds_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_sync;

	// A change is taken once the second and third stages agree
	assign next_sync = (stage2 == stage3) ? stage3 : sync_out;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stage1   <= '0;
			stage2   <= '0;
			stage3   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			stage2   <= stage1;
			stage3   <= stage2;
			sync_out <= next_sync;
		end
	end
endmodule

// ==== testbench/rlds_bank_assertions.sv ====
// Port checks for the lane debug status bank
`timescale 1ns/1ps
module rlds_bank_assertions (
	input wire logic                 clk_sys_in,
	input wire logic                 rst_n_in,
	input wire logic [7:0]           reg_addr_in,
	input wire logic [31:0]          reg_wdata_in,
	input wire logic                 reg_wr_in,
	input wire logic                 reg_rd_in,
	input wire rlds_pkg::rlds_lane_t lane_in,
	input wire logic [31:0]          reg_rdata_out,
	input wire logic                 irq_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	a_rdata_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
		else $error("read data not zero outside read");
	a_unmapped_read_zero: assert property (reg_rd_in && reg_addr_in == 8'h10 |=> reg_rdata_out == 32'h0)
		else $error("unmapped read not zero");
	a_align_word: assert property (
		$stable(lane_in)[*6] ##0 (reg_rd_in && reg_addr_in == rlds_pkg::FRAME_ALIGN_OFF)
		|=> reg_rdata_out == {16'h0, $past(lane_in.frame_align_state)}) else $error("align word wrong");
	a_buffer_word: assert property (
		$stable(lane_in)[*6] ##0 (reg_rd_in && reg_addr_in == rlds_pkg::BUF_LEVEL_OFF)
		|=> reg_rdata_out == {8'h0, $past(lane_in.rx_buffer_empty), 8'h0, $past(lane_in.sync_buffer_full)})
		else $error("buffer word wrong");
	a_phase_word: assert property (
		$stable(lane_in)[*6] ##0 (reg_rd_in && reg_addr_in == rlds_pkg::PHASE_OFF)
		|=> reg_rdata_out == {8'h0, $past(lane_in.align_config_started), 8'h0, $past(lane_in.user_payload_phase)})
		else $error("phase word wrong");
	a_irq_steady: assert property ($stable(lane_in)[*8] ##0 !reg_wr_in |=> $stable(irq_out))
		else $error("interrupt moved without cause");
endmodule

// ==== testbench/test_rlds_bank.sv ====
// Self-checking bench for the lane debug status bank
`timescale 1ns/1ps
module test_rlds_bank;
	logic clk_sys_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, rd_d = 0, irq_out;
	logic [7:0] reg_addr_in = 8'h0;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
	rlds_pkg::rlds_lane_t lane_in = '0;
	logic [31:0] q[$];
	int n_errors = 0, samples_checked = 0, cyc = 0;
	rlds_bank i_rlds_bank (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .lane_in(lane_in),
		.reg_rdata_out(reg_rdata_out), .irq_out(irq_out));
	initial begin
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("BAD t=%0t seen=%h expected=%h", $time, s, e);
		end
	endtask
	task end_of_test;
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		q.push_back(e);
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask
	always @(posedge clk_sys_in) begin
		rd_d <= reg_rd_in;
		if (rd_d) chk(reg_rdata_out, q.pop_front());
		if (++cyc > 5000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(28));
		repeat (16) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		rd(8'hf4, 32'h0); rd(8'hf8, 32'h0); rd(8'hfc, 32'h0);
		repeat (20) begin
			@(posedge clk_sys_in);
			lane_in <= 48'({$urandom, $urandom});
			wr(8'hf4, 32'hffff_ffff); wr(8'hf8, $urandom); wr(8'hfc, 32'hffff_ffff);
			rd(8'hf4, {16'h0, lane_in.frame_align_state});
			rd(8'hf8, {8'h0, lane_in.rx_buffer_empty, 8'h0, lane_in.sync_buffer_full});
			rd(8'hfc, {8'h0, lane_in.align_config_started, 8'h0, lane_in.user_payload_phase});
			rd(8'h10, 32'h0);
		end
		lane_in <= '0;
		repeat (8) @(posedge clk_sys_in);
		wr(8'he0, 32'hffff); wr(8'he4, 32'h1);
		lane_in.align_config_started <= 8'h03;
		repeat (8) @(posedge clk_sys_in);
		chk(irq_out, 1'b1);
		rd(8'he0, 32'h3); rd(8'he4, 32'h1); wr(8'he0, 32'h1);
		repeat (3) @(posedge clk_sys_in);
		chk(irq_out, 1'b0);
		lane_in.user_payload_phase <= 8'h80;
		repeat (8) @(posedge clk_sys_in);
		rd(8'he0, 32'h8002);
		repeat (3) @(posedge clk_sys_in);
		end_of_test();
	end
endmodule
bind rlds_bank rlds_bank_assertions i_rlds_bank_assertions (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.lane_in(lane_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));
